// ### swi_ctrl.sv
`default_nettype none
module swi_ctrl #(
  parameter int NPIN = swi_pkg::PB_W
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // core instruction events
  input wire logic sleep_exec_in,
  input wire logic interrupt_return_in,
  input wire logic interrupt_return_add_counter_in,
  input wire logic int_window_in,
  // configuration
  input wire logic [swi_pkg::FUSE_W-1:0] extended_config_word_in,
  input wire logic wdt_enable_in,
  // port b control write
  input wire logic ctrl_wr_in,
  input wire logic [7:0] mode_reg_in,
  input wire logic [7:0] w_reg_in,
  // context to save
  input wire logic [swi_pkg::PC_W-1:0] pc_in,
  input wire logic [7:0] bank_pointer_reg_in,
  input wire logic [7:0] status_in,
  // wake and interrupt sources
  input wire logic [NPIN-1:0] portb_pin_in,
  input wire logic wdt_overflow_in,
  input wire logic external_reset_pin_n_in,
  input wire logic realtime_counter_rollover_in,
  input wire logic realtime_counter_int_en_in,
  input wire logic [swi_pkg::TMR_SRC-1:0] timer_irq_in,
  // register views
  output logic [7:0] xchg_data_out,
  output logic [NPIN-1:0] wakeup_pin_enable_out,
  output logic [NPIN-1:0] wakeup_edge_select_out,
  output logic [NPIN-1:0] wakeup_pending_flags_out,
  // power state
  output logic powerdown_out,
  output logic opclk_run_out,
  output logic wdt_clear_out,
  output logic timeout_status_bit_out,
  output logic powerdown_status_bit_out,
  output logic wake_out,
  // program flow and context
  output logic pc_load_out,
  output logic [swi_pkg::PC_W-1:0] pc_load_val_out,
  output logic int_taken_out,
  output logic in_service_out,
  output logic page_clear_out,
  output logic ctx_restore_out,
  output logic [7:0] shadow_bank_pointer_out,
  output logic [7:0] shadow_status_out,
  output logic [7:0] shadow_mode_out,
  output logic [7:0] shadow_w_out,
  output logic realtime_counter_add_out,
  output logic [7:0] realtime_counter_add_val_out
);
  import swi_pkg::*;

  if (NPIN < 1 || NPIN > 8) begin : g_npin_check
    $error("NPIN must be 1 to 8");
  end

  // pin synchronisers and edge detect
  logic [NPIN-1:0] pin_s1_q, pin_s1_d, pin_s2_q, pin_s2_d, pin_prev_q, pin_prev_d, edge_hit;
  logic rst_s1_q, rst_s1_d, rst_s2_q, rst_s2_d;

  always_comb begin
    pin_s1_d = portb_pin_in;
    pin_s2_d = pin_s1_q;
    pin_prev_d = pin_s2_q;
    rst_s1_d = external_reset_pin_n_in;
    rst_s2_d = rst_s1_q;
  end

  always_ff @(posedge clk_in) begin
    pin_s1_q <= pin_s1_d;
    pin_s2_q <= pin_s2_d;
    pin_prev_q <= pin_prev_d;
    rst_s1_q <= rst_s1_d;
    rst_s2_q <= rst_s2_d;
  end

  for (genvar i = 0; i < NPIN; i++) begin : g_edge
    assign edge_hit[i] = wakeup_edge_select_out[i] ? (pin_prev_q[i] & ~pin_s2_q[i])
                                                   : (~pin_prev_q[i] & pin_s2_q[i]);
  end

  // control-write register group
  logic wr_pend, wr_edge, wr_en;
  logic [NPIN-1:0] en_q, en_d, edg_q, edg_d, pend_q, pend_d;
  logic [7:0] xchg_q, xchg_d;

  assign wr_pend = ctrl_wr_in && (mode_reg_in == MODE_PEND || mode_reg_in == MODE_PEND_ALT);
  assign wr_edge = ctrl_wr_in && (mode_reg_in == MODE_EDGE);
  assign wr_en = ctrl_wr_in && (mode_reg_in == MODE_EN);

  always_comb begin
    en_d = en_q;
    edg_d = edg_q;
    xchg_d = xchg_q;
    if (wr_edge) begin
      edg_d = w_reg_in[NPIN-1:0];
    end
    if (wr_en) begin
      en_d = w_reg_in[NPIN-1:0];
    end
    if (wr_pend) begin
      xchg_d = 8'h00;
      xchg_d[NPIN-1:0] = pend_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      en_q <= EN_RST[NPIN-1:0];
      edg_q <= EDGE_RST[NPIN-1:0];
      xchg_q <= 8'h00;
    end else begin
      en_q <= en_d;
      edg_q <= edg_d;
      xchg_q <= xchg_d;
    end
  end

  // an edge in the clearing cycle still sets its flag
  always_comb begin
    pend_d = pend_q;
    if (wr_pend) begin
      pend_d = w_reg_in[NPIN-1:0];
    end
    pend_d = pend_d | edge_hit;
  end

  // pending flags deliberately keep no reset value
  always_ff @(posedge clk_in) begin
    pend_q <= pend_d;
  end

  assign wakeup_pin_enable_out = en_q;
  assign wakeup_edge_select_out = edg_q;
  assign wakeup_pending_flags_out = pend_q;
  assign xchg_data_out = xchg_q;

  // interrupt and power sequencing
  swi_pwr_e pwr_q, pwr_d;
  logic svc_q, svc_d, to_q, to_d, pd_q, pd_d;
  struct packed {logic wdtc, wake, pcl, take, pgc, ctx, radd;} pls_q, pls_d;
  struct packed {logic [7:0] bank, stat, mode, w;} shd_q, shd_d;
  logic [PC_W-1:0] pcv_q, pcv_d, stk_q, stk_d;
  logic [7:0] radv_q, radv_d;
  logic ext_pend, tmr_evt, take, interrupt_return_any, pin_wake;

  // cleared enable bit lets the pin through
  // pending flags raise the external interrupt
  assign ext_pend = |(pend_q & ~en_q);
  // rollover gated by its option enable
  assign tmr_evt = (realtime_counter_rollover_in & realtime_counter_int_en_in) | (|timer_irq_in);
  // no source outranks another, none while in service
  // ext flag stays pending and is taken after return
  // timer event not remembered across service
  assign take = (pwr_q == ST_RUN) && int_window_in && !svc_q && (ext_pend || tmr_evt);
  assign interrupt_return_any = interrupt_return_in | interrupt_return_add_counter_in;
  assign pin_wake = |(edge_hit & ~en_q);

  always_comb begin
    pwr_d = pwr_q;
    svc_d = svc_q;
    to_d = to_q;
    pd_d = pd_q;
    stk_d = stk_q;
    shd_d = shd_q;
    pcv_d = pcv_q;
    radv_d = radv_q;
    pls_d = '0;
    unique case (pwr_q)
      ST_RUN: begin
        if (take) begin
          // push pc and shadow context, clear page bits
          // one stack entry, apart from call stack
          svc_d = 1'b1;
          stk_d = pc_in;
          shd_d.bank = bank_pointer_reg_in;
          shd_d.stat = status_in;
          shd_d.mode = mode_reg_in;
          shd_d.w = w_reg_in;
          pls_d.pcl = 1'b1;
          pcv_d = ISR_VEC;
          pls_d.take = 1'b1;
          pls_d.pgc = 1'b1;
        end else if (svc_q && interrupt_return_any) begin
          svc_d = 1'b0;
          pls_d.pcl = 1'b1;
          pcv_d = stk_q;
          pls_d.ctx = 1'b1;
          pls_d.radd = interrupt_return_add_counter_in;
          radv_d = w_reg_in;
        end else if (sleep_exec_in) begin
          pwr_d = ST_SLEEP;
          if (wdt_enable_in) begin
            pls_d.wdtc = 1'b1;
            to_d = 1'b1;
            pd_d = 1'b0;
          end
        end
      end
      ST_SLEEP: begin
        // watchdog, pin edge or reset pin ends power-down
        if (pin_wake || wdt_overflow_in || !rst_s2_q) begin
          pwr_d = ST_RUN;
          pls_d.wake = 1'b1;
          if (pin_wake) begin
            pls_d.pcl = 1'b1;
            pcv_d = PC_MAX;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pwr_q <= ST_RUN;
      svc_q <= 1'b0;
      to_q <= 1'b0;
      pd_q <= 1'b0;
      stk_q <= '0;
      shd_q <= '0;
      pcv_q <= '0;
      radv_q <= 8'h00;
      pls_q <= '0;
    end else begin
      pwr_q <= pwr_d;
      svc_q <= svc_d;
      to_q <= to_d;
      pd_q <= pd_d;
      stk_q <= stk_d;
      shd_q <= shd_d;
      pcv_q <= pcv_d;
      radv_q <= radv_d;
      pls_q <= pls_d;
    end
  end

  assign powerdown_out = (pwr_q == ST_SLEEP);
  // clock stops in power-down unless keep bit is cleared
  assign opclk_run_out = (pwr_q == ST_RUN) || !extended_config_word_in[FUSE_CLK_KEEP_BIT];
  assign timeout_status_bit_out = to_q;
  assign powerdown_status_bit_out = pd_q;
  assign pc_load_val_out = pcv_q;
  assign in_service_out = svc_q;
  assign realtime_counter_add_val_out = radv_q;
  assign {wdt_clear_out, wake_out, pc_load_out, int_taken_out, page_clear_out, ctx_restore_out,
          realtime_counter_add_out} = pls_q;
  assign {shadow_bank_pointer_out, shadow_status_out, shadow_mode_out, shadow_w_out} = shd_q;

  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);

  a_reset_cfg_ones: assert property (
    @(posedge clk_in) disable iff (1'b0)
    srst_in |=> (en_q == EN_RST[NPIN-1:0] && edg_q == EDGE_RST[NPIN-1:0]))
    else $error("config not all ones after reset");
  a_edge_sets_flag: assert property (
    (edge_hit != '0) |=> ((pend_q & $past(edge_hit)) == $past(edge_hit)))
    else $error("edge did not latch pending flag");
  a_sleep_entry: assert property (
    (pwr_q == ST_RUN && sleep_exec_in && !take && !(svc_q && interrupt_return_any))
    |=> powerdown_out)
    else $error("sleep not entered");
  a_sleep_wdt_status: assert property (
    (pwr_q == ST_RUN && sleep_exec_in && wdt_enable_in && !take && !(svc_q && interrupt_return_any))
    |=> (wdt_clear_out && timeout_status_bit_out && !powerdown_status_bit_out))
    else $error("watchdog sleep status wrong");
  a_pin_wake_top: assert property (
    (pwr_q == ST_SLEEP && pin_wake)
    |=> (pc_load_out && pc_load_val_out == PC_MAX && !powerdown_out && wake_out))
    else $error("pin wake did not restart at top");
  a_take_vector: assert property (
    take |=> (int_taken_out && pc_load_val_out == ISR_VEC && in_service_out
              && shadow_w_out == $past(w_reg_in) && page_clear_out))
    else $error("interrupt entry wrong");
  a_no_nesting: assert property (
    (svc_q && !interrupt_return_any) |=> (!int_taken_out && in_service_out))
    else $error("interrupt taken during service");
  a_return_restore: assert property (
    (pwr_q == ST_RUN && svc_q && interrupt_return_any)
    |=> (ctx_restore_out && !in_service_out && pc_load_val_out == $past(stk_q)
         && realtime_counter_add_out == $past(interrupt_return_add_counter_in)))
    else $error("return did not restore");
  a_pend_exchange: assert property (
    wr_pend |=> (xchg_data_out[NPIN-1:0] == $past(pend_q)))
    else $error("pending exchange wrong");
  a_masked_quiet: assert property (
    ((pend_q & ~en_q) == '0 && !tmr_evt) |=> !int_taken_out)
    else $error("disabled pin raised interrupt");

  c_ext_take: cover property (ext_pend && take);
  c_pin_wake: cover property (pwr_q == ST_SLEEP && pin_wake);
  c_interrupt_return_add_counter: cover property (svc_q && interrupt_return_add_counter_in ##1 realtime_counter_add_out);

endmodule // swi_ctrl
`default_nettype wire

// ### swi_pkg.sv
`default_nettype none
package swi_pkg;
  // port b width and control-write mode codes
  localparam int PB_W = 8;
  localparam logic [7:0] MODE_PEND = 8'h19;
  localparam logic [7:0] MODE_PEND_ALT = 8'h09;
  localparam logic [7:0] MODE_EDGE = 8'h1A;
  localparam logic [7:0] MODE_EN = 8'h1B;
  // reset values
  localparam logic [7:0] EN_RST = 8'hFF;
  localparam logic [7:0] EDGE_RST = 8'hFF;
  // extended configuration word
  localparam int FUSE_W = 12;
  localparam int FUSE_CLK_KEEP_BIT = 11;
  // program counter and vectors
  localparam int PC_W = 12;
  localparam logic [PC_W-1:0] PC_MAX = 12'hFFF;
  localparam logic [PC_W-1:0] ISR_VEC = 12'h000;
  // timer interrupt sources: t1 and t2, overflow / compare / capture each
  localparam int TMR_SRC = 6;
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_SLEEP = 2'b10
  } swi_pwr_e;
endpackage
`default_nettype wire

// ### swi_far.sv
`default_nettype none
module swi_far #(
  parameter int WDT_DLY = 5
) (
  // clock and bench requests
  input wire logic clk_in,
  input wire logic [7:0] pin_lvl_in,
  input wire logic wdt_kick_in,
  input wire logic rst_req_in,
  // pins seen by the block
  output logic [7:0] portb_pin_out,
  output logic wdt_overflow_out,
  output logic external_reset_pin_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int wcnt = 0;
  int rcnt = 0;
  assign portb_pin_out = pin_lvl_in;
  always @(posedge clk_in) begin
    wdt_overflow_out <= (wcnt == 1);
    if (wdt_kick_in) wcnt <= WDT_DLY;
    else if (wcnt > 0) wcnt <= wcnt - 1;
  end
  // reset pin low long enough to pass the synchroniser
  always @(posedge clk_in) begin
    external_reset_pin_n_out <= !(rcnt > 0);
    if (rst_req_in) rcnt <= 4;
    else if (rcnt > 0) rcnt <= rcnt - 1;
  end
endmodule // swi_far
`default_nettype wire

// ### sleep_wakeup_interrupt_ctrl_bench.sv
`default_nettype none
module sleep_wakeup_interrupt_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import swi_pkg::*;
  logic clk_in = 0, srst_in = 1, slp = 0, interrupt_return = 0, interrupt_return_add_counter = 0, win = 0, wden = 0;
  logic wr = 0, kick = 0, rreq = 0, realtime_counter = 0, rten = 0;
  logic [11:0] cfg = 12'h000, pc = 12'h123, last_pc;
  logic [7:0] mode = 8'h00, w = 8'h00, pins = 8'h04, xd, en, ed, pd, sb, ss, sm, sw, av;
  logic [7:0] pb;
  logic [5:0] tmr = 6'h00;
  logic pdn, opk, wdc, to, pds, wk, pcl, itk, ins, pgc, rst, add, wov, rpn;
  int num_errors = 0, check_count = 0, cyc_n = 0;
  int n_int = 0, n_wake = 0, n_rest = 0, n_wdc = 0, n_add = 0, n_pgc = 0, n_pcl = 0;
  swi_far u_far (.clk_in(clk_in), .pin_lvl_in(pins), .wdt_kick_in(kick), .rst_req_in(rreq),
    .portb_pin_out(pb), .wdt_overflow_out(wov), .external_reset_pin_n_out(rpn));
  swi_ctrl u_dut (.clk_in(clk_in), .srst_in(srst_in), .sleep_exec_in(slp), .interrupt_return_in(interrupt_return),
    .interrupt_return_add_counter_in(interrupt_return_add_counter), .int_window_in(win), .extended_config_word_in(cfg),
    .wdt_enable_in(wden), .ctrl_wr_in(wr), .mode_reg_in(mode), .w_reg_in(w), .pc_in(pc),
    .bank_pointer_reg_in(8'h33), .status_in(8'h5A), .portb_pin_in(pb),
    .wdt_overflow_in(wov), .external_reset_pin_n_in(rpn), .realtime_counter_rollover_in(realtime_counter),
    .realtime_counter_int_en_in(rten), .timer_irq_in(tmr), .xchg_data_out(xd),
    .wakeup_pin_enable_out(en), .wakeup_edge_select_out(ed), .wakeup_pending_flags_out(pd),
    .powerdown_out(pdn), .opclk_run_out(opk), .wdt_clear_out(wdc),
    .timeout_status_bit_out(to), .powerdown_status_bit_out(pds), .wake_out(wk),
    .pc_load_out(pcl), .pc_load_val_out(last_pc), .int_taken_out(itk),
    .in_service_out(ins), .page_clear_out(pgc), .ctx_restore_out(rst),
    .shadow_bank_pointer_out(sb), .shadow_status_out(ss), .shadow_mode_out(sm),
    .shadow_w_out(sw), .realtime_counter_add_out(add), .realtime_counter_add_val_out(av));
  initial forever #5 clk_in = ~clk_in;
  // pulses are counted once settled, between rising edges
  always @(negedge clk_in) begin
    n_int += (itk === 1'b1);
    n_wake += (wk === 1'b1);
    n_rest += (rst === 1'b1);
    n_wdc += (wdc === 1'b1);
    n_add += (add === 1'b1);
    n_pgc += (pgc === 1'b1);
    n_pcl += (pcl === 1'b1);
  end
  always @(posedge clk_in) begin
    cyc_n++;
    if (cyc_n == 3000) begin
      num_errors++;
      results();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cwr(input logic [7:0] m, input logic [7:0] v);
    wr = 1;
    mode = m;
    w = v;
    cyc(1);
    wr = 0;
    cyc(1);
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    cyc(1);
    s = 0;
    cyc(1);
  endtask
  task automatic results();
    if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    cyc(2);
    srst_in = 0;
    chk(en, EN_RST);
    chk(ed, EDGE_RST);
    chk(pdn, 1'b0);
    // edges first, then clear pending, then enable
    cwr(MODE_EDGE, 8'h05);
    cwr(MODE_PEND, 8'h00);
    cwr(MODE_EN, 8'hF8);
    chk(pd, 8'h00);
    pins = 8'h06;
    cyc(5);
    chk(pd, 8'h02);
    pins = 8'h07;
    cyc(5);
    chk(pd, 8'h02);
    cwr(MODE_PEND_ALT, 8'h00);
    chk(xd, 8'h02);
    chk(pd, 8'h00);
    cwr(8'h1F, 8'hAA);
    chk({en, ed}, 16'hF805);
    chk(pd, 8'h00);
    pins = 8'h06;
    win = 1;
    cyc(6);
    chk(n_int, 1);
    chk(last_pc, ISR_VEC);
    chk(ins, 1'b1);
    chk({sb, ss}, 16'h335A);
    chk({sm, sw}, 16'h1FAA);
    chk(n_pgc, 1);
    // second edge and a timer event while serving
    pins = 8'h02;
    pc = 12'h456;
    tmr = 6'h01;
    cyc(1);
    tmr = 6'h00;
    cyc(1);
    cyc(5);
    chk(pd, 8'h05);
    chk(n_int, 1);
    // clear only the flag being handled
    cwr(MODE_PEND, 8'h04);
    chk(xd, 8'h05);
    pulse(interrupt_return);
    cyc(3);
    chk(n_rest, 1);
    chk(n_int, 2);
    chk(last_pc, 12'h000);
    cwr(MODE_PEND, 8'h00);
    w = 8'h3C;
    pulse(interrupt_return_add_counter);
    cyc(3);
    chk(n_add, 1);
    chk(av, 8'h3C);
    chk(last_pc, 12'h456);
    chk(n_int, 2);
    // rollover ignored until its option enable is set
    pulse(realtime_counter);
    chk(n_int, 2);
    rten = 1;
    pulse(realtime_counter);
    chk(n_int, 3);
    pulse(interrupt_return);
    tmr = 6'h20;
    cyc(1);
    tmr = 6'h00;
    cyc(4);
    chk(n_int, 4);
    win = 0;
    pulse(interrupt_return);
    wden = 1;
    pulse(slp);
    cyc(2);
    chk({pdn, to, pds, opk}, 4'hD);
    chk(n_wdc, 1);
    pulse(kick);
    cyc(10);
    chk(pdn, 1'b0);
    chk(n_wake, 1);
    cfg = 12'h800;
    pulse(slp);
    chk({pdn, opk}, 2'b10);
    pins = 8'h03;
    cyc(6);
    chk(pdn, 1'b1);
    pins = 8'h02;
    cyc(6);
    chk(n_wake, 2);
    chk(last_pc, PC_MAX);
    pulse(slp);
    chk(pdn, 1'b1);
    pulse(rreq);
    cyc(10);
    chk(n_wake, 3);
    chk(pdn, 1'b0);
    chk(n_pcl, 9);
    results();
  end
endmodule // sleep_wakeup_interrupt_ctrl_bench
`default_nettype wire
